// ==== kpm_defs.svh ====
// Constants of the keypad setup menu controller
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`ifndef KPM_DEFS_SVH
`define KPM_DEFS_SVH
// Timing
`define KPM_CLK_KHZ 100000
`define KPM_HOLD_MS 500
// Register byte offsets
`define KPM_A_STAT 8'h00
`define KPM_A_DISP 8'h04
`define KPM_A_PV1 8'h08
`define KPM_A_PV2 8'h0c
`define KPM_A_CTRL 8'h10
`define KPM_A_MM1 8'h14
`define KPM_A_MM2 8'h18
// Control register fields
`define KPM_CTRL_FAIL1 0
`define KPM_CTRL_FAIL2 1
`define KPM_CTRL_MMCLR 2
// Setting indices, also prompt number minus one
`define KPM_S_P1 5'h00
`define KPM_S_P2 5'h01
`define KPM_S_Z1 5'h02
`define KPM_S_S1 5'h03
`define KPM_S_Z2 5'h04
`define KPM_S_S2 5'h05
`define KPM_S_F1 5'h06
`define KPM_S_F2 5'h07
`define KPM_S_L1 5'h08
`define KPM_S_H1 5'h09
`define KPM_S_L2 5'h0a
`define KPM_S_H2 5'h0b
`define KPM_S_HY 5'h0c
`define KPM_S_A1 5'h0d
`define KPM_S_A2 5'h0e
`define KPM_S_UN 5'h0f
`define KPM_S_BA 5'h10
`define KPM_S_AC 5'h11
`define KPM_NSET 18
// Factory values
`define KPM_D_P1 11'sh000
`define KPM_D_P2 11'sh004
`define KPM_D_Z1 11'sh00a
`define KPM_D_S1 11'sh05a
`define KPM_D_Z2 11'sh000
`define KPM_D_S2 11'sh03c
`define KPM_D_L1 11'sh014
`define KPM_D_H1 11'sh03c
`define KPM_D_L2 11'sh005
`define KPM_D_H2 11'sh032
`define KPM_D_HY 11'sh001
`define KPM_D_OFF 11'sh000
// Limits
`define KPM_MAX_RH 11'sh063
`define KPM_MAX_AH 11'sh258
`define KPM_MAX_SE 11'sh3e7
`define KPM_MAX_TA 11'sh064
`define KPM_MAX_TD 11'sh03c
`define KPM_SPAN_MIN 11'sh00a
`define KPM_HY_MAX 11'sh00a
`define KPM_AM_MAX 11'sh004
`define KPM_BA_LIM 11'sh063
`define KPM_P1_MAX 11'sh003
`define KPM_P2_MIN 11'sh004
`define KPM_P2_MAX 11'sh006
`endif

// ==== kpm_pkg.sv ====
// Types shared by the keypad menu files
package kpm_pkg;
    typedef logic signed [10:0] kpm_val_type;
    typedef enum logic [1:0] {
        MS_MEAS  = 2'b00,
        MS_MAXMN = 2'b01,
        MS_SETUP = 2'b10,
        MS_EDIT  = 2'b11
    } kpm_mode_type;
    typedef struct packed {
        logic confirm_key;
        logic up_key;
        logic down_key;
    } kpm_keys_type;
    typedef struct packed {
        kpm_val_type upper;
        kpm_val_type lower;
    } kpm_disp_type;
endpackage

// ==== kpm_key.sv ====
// Hold qualifier for one front-panel key
`timescale 1ns/10ps
module kpm_key #(
    parameter int HOLD_CYC = 50000000
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic key,
    output logic      held_r,
    output logic      press_r
);
    logic [31:0] cnt_r;

    // ------------------------------------------------------------
    // Press accepted only after a full hold, so taps are ignored
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_r   <= 32'h0;
            held_r  <= 1'b0;
            press_r <= 1'b0;
        end
        else if (!key)
        begin
            cnt_r   <= 32'h0;
            held_r  <= 1'b0;
            press_r <= 1'b0;
        end
        else
        begin
            if (cnt_r < 32'(HOLD_CYC)) cnt_r <= cnt_r + 32'h1;
            press_r <= (cnt_r == 32'(HOLD_CYC - 1));
            held_r  <= (cnt_r >= 32'(HOLD_CYC - 1));
        end
    end
endmodule // kpm_key

// ==== kpm_store.sv ====
// Setting store, loaded with factory values at reset
`timescale 1ns/10ps
module kpm_store #(
    parameter int N = 18,
    parameter int W = 11,
    parameter logic [N*W-1:0] INIT = '0
) (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           we,
    input  wire logic [4:0]     waddr,
    input  wire logic [W-1:0]   wdata,
    input  wire logic [4:0]     raddr,
    output logic      [W-1:0]   rdata_r,
    output logic      [N*W-1:0] all_r
);
    // Whole array is visible so alarm logic needs no read port
    always_ff @(posedge clk)
    begin
        if (!rst_n) all_r <= INIT;
        else if (we && int'(waddr) < N) all_r[waddr*W +: W] <= wdata;
    end

    // Registered read port for the editor
    always_ff @(posedge clk)
    begin
        if (!rst_n) rdata_r <= '0;
        else if (int'(raddr) < N) rdata_r <= all_r[raddr*W +: W];
        else rdata_r <= '0;
    end
endmodule // kpm_store

// ==== kpm_menu.sv ====
// Keypad menu controller with AHB-Lite register slave
//
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "kpm_defs.svh"
module kpm_menu #(
    parameter int HOLD_CYC = `KPM_HOLD_MS * `KPM_CLK_KHZ,
    parameter bit DUAL_OUT = 1'b1
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire kpm_pkg::kpm_keys_type keys,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    output kpm_pkg::kpm_disp_type      disp,
    output kpm_pkg::kpm_mode_type      mode,
    output logic [1:0]                 sw,
    output logic [1:0]                 lamp,
    output logic [1:0]                 fail,
    output logic [1:0]                 fail_up,
    output logic                       unit_f,
    output logic                       act_ch
);
    import kpm_pkg::*;
    localparam int W = 11;
    localparam int N_BITS = `KPM_NSET * W;

    kpm_mode_type  mode_r;
    logic [4:0]    prompt_r;
    kpm_val_type   edit_r;
    logic          browse_r;
    kpm_val_type   pv1_r, pv2_r, max1_r, min1_r, max2_r, min2_r;
    logic [2:0]    ctrl_r;
    logic          pend_r, pwr_r;
    logic [7:0]    paddr_r;
    logic [2:0]    prs, hld;
    logic          combo_d_r, combo, up_p, dn_p, cf_p, mem_we;
    logic [N_BITS-1:0] all;
    kpm_val_type   rd, lo, hi, max1, max2;
    logic [4:0]    last;

    localparam logic [N_BITS-1:0] INIT = {
        `KPM_D_OFF, `KPM_D_OFF, `KPM_D_OFF, `KPM_D_OFF, `KPM_D_OFF,
        `KPM_D_HY,  `KPM_D_H2,  `KPM_D_L2,  `KPM_D_H1,  `KPM_D_L1,
        `KPM_D_OFF, `KPM_D_OFF, `KPM_D_S2,  `KPM_D_Z2,  `KPM_D_S1,
        `KPM_D_Z1,  `KPM_D_P2,  `KPM_D_P1};

    // ------------------------------------------------------------
    // Key qualification
    // ------------------------------------------------------------
    for (genvar k = 0; k < 3; k++)
    begin : g_key
        kpm_key #(.HOLD_CYC(HOLD_CYC)) u_key (
            .clk     (clk),
            .rst_n   (rst_n),
            .key     (keys[k]),
            .held_r  (hld[k]),
            .press_r (prs[k])
        );
    end

    // Bit 2 confirm, bit 1 up, bit 0 down; a lone key counts only
    // when its partner is not held, so a combo never scrolls
    assign combo = hld[1] & hld[0] & ~combo_d_r;
    assign up_p  = prs[1] & ~hld[0] & ~keys.down_key;
    assign dn_p  = prs[0] & ~hld[1] & ~keys.up_key;
    assign cf_p  = prs[2];

    always_ff @(posedge clk)
    begin
        if (!rst_n) combo_d_r <= 1'b0;
        else combo_d_r <= hld[1] & hld[0];
    end

    // ------------------------------------------------------------
    // Setting store
    // ------------------------------------------------------------
    assign mem_we = (mode_r == MS_EDIT) && cf_p;
    kpm_store #(.N(`KPM_NSET), .W(W), .INIT(INIT)) u_store (
        .clk     (clk),
        .rst_n   (rst_n),
        .we      (mem_we),
        .waddr   (prompt_r),
        .wdata   (edit_r),
        .raddr   (prompt_r),
        .rdata_r (rd),
        .all_r   (all)
    );

    function automatic kpm_val_type cfg(input logic [4:0] i);
        cfg = all[i*W +: W];
    endfunction

    // ------------------------------------------------------------
    // Edit limits per prompt
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (cfg(`KPM_S_P1))
            11'sh000: max1 = `KPM_MAX_RH;
            11'sh001, 11'sh002: max1 = `KPM_MAX_AH;
            default: max1 = `KPM_MAX_SE;
        endcase
        max2 = (cfg(`KPM_S_P2) == `KPM_P2_MIN) ? `KPM_MAX_TA
                                                : `KPM_MAX_TD;
    end

    always_comb
    begin
        lo = 11'sh000;
        hi = 11'sh001;
        unique case (prompt_r)
            `KPM_S_P1: hi = `KPM_P1_MAX;
            `KPM_S_P2:
            begin
                lo = `KPM_P2_MIN;
                hi = `KPM_P2_MAX;
            end
            `KPM_S_Z1: hi = cfg(`KPM_S_S1) - `KPM_SPAN_MIN;
            `KPM_S_S1:
            begin
                lo = cfg(`KPM_S_Z1) + `KPM_SPAN_MIN;
                hi = max1;
            end
            `KPM_S_Z2: hi = cfg(`KPM_S_S2) - `KPM_SPAN_MIN;
            `KPM_S_S2:
            begin
                lo = cfg(`KPM_S_Z2) + `KPM_SPAN_MIN;
                hi = max2;
            end
            `KPM_S_L1, `KPM_S_H1:
            begin
                lo = cfg(`KPM_S_Z1) + 11'sh001;
                hi = cfg(`KPM_S_S1) - 11'sh001;
            end
            `KPM_S_L2, `KPM_S_H2:
            begin
                lo = cfg(`KPM_S_Z2) + 11'sh001;
                hi = cfg(`KPM_S_S2) - 11'sh001;
            end
            `KPM_S_HY: hi = `KPM_HY_MAX;
            `KPM_S_A1, `KPM_S_A2: hi = `KPM_AM_MAX;
            `KPM_S_BA:
            begin
                lo = -`KPM_BA_LIM;
                hi = `KPM_BA_LIM;
            end
            default: hi = 11'sh001;
        endcase
    end

    // Active-output prompt exists only on the dual variant
    assign last = DUAL_OUT ? `KPM_S_AC : `KPM_S_BA;

    // ------------------------------------------------------------
    // Menu state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode_r   <= MS_MEAS;
            prompt_r <= `KPM_S_P1;
            browse_r <= 1'b0;
        end
        else
        begin
            unique case (mode_r)
                MS_MEAS:
                    if (combo)
                    begin
                        mode_r   <= MS_SETUP;
                        prompt_r <= `KPM_S_P1;
                    end
                    else if (cf_p) mode_r <= MS_MAXMN;
                    else if (up_p || dn_p) browse_r <= ~browse_r;
                MS_MAXMN:
                    if (cf_p) mode_r <= MS_MEAS;
                MS_SETUP:
                    if (combo) mode_r <= MS_MEAS;
                    else if (cf_p) mode_r <= MS_EDIT;
                    else if (up_p)
                        prompt_r <= (prompt_r == last) ? `KPM_S_P1
                                                       : prompt_r + 5'h1;
                    else if (dn_p)
                        prompt_r <= (prompt_r == `KPM_S_P1) ? last
                                                            : prompt_r - 5'h1;
                MS_EDIT:
                    if (cf_p)
                    begin
                        mode_r   <= MS_SETUP;
                        prompt_r <= (prompt_r == last) ? `KPM_S_P1
                                                       : prompt_r + 5'h1;
                    end
            endcase
        end
    end

    // Edited value, saturating at both limits
    always_ff @(posedge clk)
    begin
        if (!rst_n) edit_r <= 11'sh000;
        else if (mode_r == MS_SETUP && cf_p) edit_r <= rd;
        else if (mode_r == MS_EDIT)
        begin
            if (up_p)
                edit_r <= (edit_r >= hi) ? hi : edit_r + 11'sh001;
            else if (dn_p)
                edit_r <= (edit_r <= lo) ? lo : edit_r - 11'sh001;
        end
    end

    // ------------------------------------------------------------
    // Max/min records, cleared by reset or by software
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n || ctrl_r[`KPM_CTRL_MMCLR])
        begin
            max1_r <= 11'sh400;
            min1_r <= 11'sh3ff;
            max2_r <= 11'sh400;
            min2_r <= 11'sh3ff;
        end
        else
        begin
            if (pv1_r > max1_r) max1_r <= pv1_r;
            if (pv1_r < min1_r) min1_r <= pv1_r;
            if (pv2_r > max2_r) max2_r <= pv2_r;
            if (pv2_r < min2_r) min2_r <= pv2_r;
        end
    end

    // ------------------------------------------------------------
    // Alarm switches, lamps and fail outputs
    // ------------------------------------------------------------
    function automatic logic [1:0] alarm(input kpm_val_type pv,
        input kpm_val_type lt, input kpm_val_type ht,
        input kpm_val_type md);
        logic t;
        t = 1'b0;
        unique case (md)
            11'sh001: t = pv > lt;
            11'sh002: t = pv < lt;
            11'sh003, 11'sh004: t = (pv > lt) && (pv < ht);
            default: t = 1'b0;
        endcase
        // Bit 1 lamp, bit 0 switch; even modes open on trip
        alarm = {t, md[0] ? t : (md == 11'sh000 ? 1'b0 : ~t)};
    endfunction

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            {lamp[0], sw[0]} <= 2'b00;
            {lamp[1], sw[1]} <= 2'b00;
        end
        else
        begin
            {lamp[0], sw[0]} <= alarm(pv1_r, cfg(`KPM_S_L1),
                cfg(`KPM_S_H1), cfg(`KPM_S_A1));
            {lamp[1], sw[1]} <= alarm(pv2_r, cfg(`KPM_S_L2),
                cfg(`KPM_S_H2), cfg(`KPM_S_A2));
        end
    end

    // Failure is reported only while measuring
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fail    <= 2'b00;
            fail_up <= 2'b00;
            unit_f  <= 1'b0;
            act_ch  <= 1'b0;
        end
        else
        begin
            fail <= (mode_r == MS_MEAS) ? ctrl_r[1:0] : 2'b00;
            fail_up <= {cfg(`KPM_S_F2) == 11'sh001,
                        cfg(`KPM_S_F1) == 11'sh001};
            unit_f <= cfg(`KPM_S_UN) == 11'sh001;
            act_ch <= DUAL_OUT && cfg(`KPM_S_AC) == 11'sh001;
        end
    end

    // ------------------------------------------------------------
    // Display and mode outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            disp <= '0;
            mode <= MS_MEAS;
        end
        else
        begin
            mode <= mode_r;
            unique case (mode_r)
                MS_MEAS: disp <= browse_r ?
                    {cfg(`KPM_S_P1), cfg(`KPM_S_P2)} : {pv1_r, pv2_r};
                MS_MAXMN: disp <= {max1_r, min1_r};
                MS_SETUP: disp <= {11'(prompt_r) + 11'sh001, 11'sh000};
                MS_EDIT: disp <= {11'(prompt_r) + 11'sh001, edit_r};
            endcase
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave, one wait state per transfer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pend_r    <= 1'b0;
            pwr_r     <= 1'b0;
            paddr_r   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0;
        end
        else if (pend_r)
        begin
            pend_r    <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0;
            if (!pwr_r)
                unique case (paddr_r)
                    `KPM_A_STAT: hrdata <= {23'h0, prompt_r, 2'h0,
                                            mode_r};
                    `KPM_A_DISP: hrdata <= {5'h0, disp.upper, 5'h0,
                                            disp.lower};
                    `KPM_A_PV1: hrdata <= {21'h0, pv1_r};
                    `KPM_A_PV2: hrdata <= {21'h0, pv2_r};
                    `KPM_A_CTRL: hrdata <= {29'h0, ctrl_r};
                    `KPM_A_MM1: hrdata <= {5'h0, max1_r, 5'h0, min1_r};
                    `KPM_A_MM2: hrdata <= {5'h0, max2_r, 5'h0, min2_r};
                    default: hrdata <= 32'h0;
                endcase
        end
        else if (hsel && htrans[1] && hready)
        begin
            pend_r    <= 1'b1;
            pwr_r     <= hwrite;
            paddr_r   <= haddr[7:0];
            hreadyout <= 1'b0;
        end
    end

    // Writable registers; clear bit of the records self-clears
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pv1_r  <= 11'sh000;
            pv2_r  <= 11'sh000;
            ctrl_r <= 3'h0;
        end
        else
        begin
            ctrl_r[`KPM_CTRL_MMCLR] <= 1'b0;
            if (pend_r && pwr_r)
                unique case (paddr_r)
                    `KPM_A_PV1: pv1_r <= hwdata[10:0];
                    `KPM_A_PV2: pv2_r <= hwdata[10:0];
                    `KPM_A_CTRL: ctrl_r <= hwdata[2:0];
                    default: ;
                endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_open;
        mode_r == MS_SETUP && cf_p && !combo;
    endsequence
    sequence s_save;
        mode_r == MS_EDIT && cf_p;
    endsequence

    chk_boot_meas: assert property (@(posedge clk)
        !rst_n |=> mode_r == MS_MEAS)
        else $error("not in measuring mode after reset");
    chk_maxmin_show: assert property (@(posedge clk)
        disable iff (!rst_n) mode_r == MS_MEAS && cf_p && !combo
        |=> mode_r == MS_MAXMN)
        else $error("confirm did not show max/min");
    chk_meas_nowrite: assert property (@(posedge clk)
        disable iff (!rst_n) mode_r == MS_MEAS && (up_p || dn_p)
        |=> all == $past(all))
        else $error("browse changed a stored setting");
    chk_setup_enter: assert property (@(posedge clk)
        disable iff (!rst_n) mode_r == MS_MEAS && combo
        |=> mode_r == MS_SETUP && prompt_r == `KPM_S_P1)
        else $error("combo did not enter setup");
    chk_prompt_step: assert property (@(posedge clk)
        disable iff (!rst_n) mode_r == MS_SETUP && up_p && !cf_p
        && !combo && prompt_r < last
        |=> prompt_r == $past(prompt_r) + 5'h1)
        else $error("up did not advance prompt");
    chk_edit_open: assert property (@(posedge clk)
        disable iff (!rst_n) s_open
        |=> mode_r == MS_EDIT && edit_r == $past(rd))
        else $error("edit did not load stored value");
    chk_save_next: assert property (@(posedge clk)
        disable iff (!rst_n) s_save
        |-> mem_we ##1 mode_r == MS_SETUP ##1 all[$past(prompt_r, 2)
        * W +: W] == $past(edit_r, 2))
        else $error("confirm did not save value");
    chk_edit_sat: assert property (@(posedge clk)
        disable iff (!rst_n) mode_r == MS_EDIT && up_p && !cf_p
        && edit_r >= hi |=> edit_r == $past(hi))
        else $error("edit value passed upper limit");
    chk_fail_drive: assert property (@(posedge clk)
        disable iff (!rst_n) mode_r == MS_MEAS && ctrl_r[0]
        |=> fail[0])
        else $error("fail output not driven");
    chk_alarm_off: assert property (@(posedge clk)
        disable iff (!rst_n) cfg(`KPM_S_A1) == 11'sh000
        |=> !lamp[0] && !sw[0])
        else $error("disabled alarm tripped");
endmodule // kpm_menu

// ==== kpm_oper.sv ====
// Operator model pressing the three front-panel keys
`timescale 1ns/10ps
module kpm_oper #(
    parameter int HOLD = 4
) (
    input  wire logic             clk,
    output kpm_pkg::kpm_keys_type keys
);
    import kpm_pkg::*;
    // ---------------------------------------------------------------
    // Key presses
    // ---------------------------------------------------------------
    // Keys rest released from time zero
    initial keys = '0;
    // Held past the qualifying count, then released long enough to
    // re-arm; a quick tap would never register
    task automatic press(input kpm_keys_type k);
        keys <= k;
        repeat (HOLD + 2) @(posedge clk);
        keys <= '0;
        repeat (4) @(posedge clk);
    endtask
endmodule // kpm_oper

// ==== tb_top.sv ====
// Self-checking bench for the keypad menu controller
`timescale 1ns/10ps
`include "kpm_defs.svh"
module tb_top;
    import kpm_pkg::*;
    // ---------------------------------------------------------------
    // Signals and model state
    // ---------------------------------------------------------------
    logic         clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
    logic [31:0]  haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]   htrans = 0, sw, lamp, fail, fail_up;
    logic [2:0]   hsize = 3'h2;
    logic         hreadyout, hresp, unit_f, act_ch;
    kpm_keys_type keys;
    kpm_disp_type disp;
    kpm_mode_type mode;
    int           err_count = 0, checked = 0, cyc = 0, a, b, c, n;
    int           dflt[18] = '{0, 4, 10, 90, 0, 60, 0, 0, 20, 60,
                               5, 50, 1, 0, 0, 0, 0, 0};
    localparam kpm_keys_type CF = 3'b100, UP = 3'b010, DN = 3'b001;
    localparam logic [23:0]  ALL = 24'hffffff;
    always #5 clk = ~clk;
    kpm_oper #(.HOLD(4)) op (.clk(clk), .keys(keys));
    kpm_menu #(.HOLD_CYC(4), .DUAL_OUT(1'b1)) DUT (.clk(clk),
        .rst_n(rst_n), .keys(keys), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .disp(disp), .mode(mode),
        .sw(sw), .lamp(lamp), .fail(fail), .fail_up(fail_up),
        .unit_f(unit_f), .act_ch(act_ch));
    // ---------------------------------------------------------------
    // Compare, bus and closing tasks
    // ---------------------------------------------------------------
    task automatic chk_val(string s, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    // Mode and both display words at once; the mask can narrow it
    task automatic chk_ui(string s, int m, u, l, logic [23:0] k);
        chk_val(s, {2'(m), 11'(u), 11'(l)} & k, {mode, disp} & k);
    endtask
    // Single word transfer; waits on hready, never a fixed count
    task automatic ahb(bit w, logic [31:0] ad, d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= ad;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk_val("hresp", 0, hresp);
    endtask
    // Walk up to a prompt, raise its stored code by one and save it
    task automatic bump(int s);
        repeat (s) op.press(UP);
        op.press(CF);
        op.press(UP);
        op.press(CF);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard, well above the fewer than two thousand cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            finish_test();
        end
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(37718));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk_ui("reset", 0, 0, 0, ALL);
        chk_val("pins", 0, {sw, lamp, fail_up, unit_f, act_ch});
        a = int'($urandom_range(900)) - 450;
        b = int'($urandom_range(900)) - 450;
        c = int'($urandom_range(200)) - 100;
        ahb(1, `KPM_A_PV1, a, rd);
        ahb(1, `KPM_A_CTRL, 32'h5, rd);
        ahb(0, `KPM_A_CTRL, 0, rd);
        chk_val("ctrl", 32'h1, rd);
        chk_val("fail", 32'h1, {fail_up, fail});
        ahb(1, `KPM_A_PV1, b, rd);
        ahb(1, `KPM_A_PV2, c, rd);
        ahb(1, `KPM_A_CTRL, 0, rd);
        ahb(1, 32'h40, 32'h5a, rd);
        ahb(0, 32'h40, 0, rd);
        chk_val("unmapped", 0, rd);
        ahb(0, `KPM_A_PV1, 0, rd);
        chk_val("pv1", b & 32'h7ff, rd);
        $display("test bus done");
        op.press(CF);
        chk_ui("maxmin", 1, a > b ? a : b, a < b ? a : b, ALL);
        op.press(CF);
        op.press(UP);
        chk_ui("browse", 0, 0, 4, ALL);
        op.press(DN);
        chk_ui("pv", 0, b, c, ALL);
        // Records saw zero before c, so they span zero and c
        n = c < 0 ? c : 0;
        ahb(0, `KPM_A_MM2, 0, rd);
        chk_val("mm2", {5'h0, 11'(c - n), 5'h0, 11'(n)}, rd);
        $display("test measuring done");
        op.press(UP | DN);
        chk_ui("setup", 2, 1, 0, ALL);
        ahb(0, `KPM_A_STAT, 0, rd);
        chk_val("stat", 32'h00000002, rd);
        ahb(0, `KPM_A_DISP, 0, rd);
        chk_val("disp", 32'h00010000, rd);
        for (int i = 0; i < 18; i++)
        begin
            op.press(CF);
            chk_ui("open", 3, i + 1, dflt[i], ALL);
            op.press(CF);
            chk_ui("next", 2, (i + 1) % 18 + 1, 0, ALL);
        end
        $display("test walk done");
        op.press(CF);
        op.press(DN);
        chk_ui("p1 low", 3, 1, 0, ALL);
        repeat (5) op.press(UP);
        chk_ui("p1 high", 3, 1, 3, ALL);
        repeat (3) op.press(CF);
        op.press(CF);
        n = 72 + int'($urandom_range(7));
        repeat (n) op.press(UP);
        chk_ui("zero", 3, 3, 80, ALL);
        op.press(CF);
        op.press(CF);
        repeat (3) op.press(DN);
        chk_ui("span", 3, 4, 90, ALL);
        op.press(CF);
        op.press(UP | DN);
        chk_ui("exit", 0, b, c, ALL);
        op.press(UP | DN);
        op.press(CF);
        chk_ui("kept", 3, 1, 3, ALL);
        $display("test limits done");
        // Fail code, alarm mode, unit and active output all set to 1
        op.press(CF);
        bump(5);
        bump(6);
        bump(1);
        bump(1);
        op.press(UP | DN);
        ahb(1, `KPM_A_PV1, a, rd);
        repeat (2) @(posedge clk);
        n = a > dflt[8];
        chk_val("sw lamp", {2'(n), 2'(n)}, {sw, lamp});
        chk_val("codes", 4'h7, {fail_up, unit_f, act_ch});
        $display("test outputs done");
        // Second reset in mid-run must reload the factory settings
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk_val("pins2", 0, {sw, lamp, fail_up, unit_f, act_ch});
        chk_ui("reset2", 0, 0, 0, ALL);
        op.press(UP | DN);
        op.press(CF);
        chk_ui("reload", 3, 1, 0, ALL);
        $display("test reset done");
        finish_test();
    end
endmodule // tb_top
